// ---- rtl/brs_batch_record_store.sv ----
// Batch record store: buffers scans and sends them out oldest first, or newest first when LIFO order is selected
module brs_batch_record_store import brs_pkg::*; #(
    parameter int DEPTH = 16,
    parameter int DATA_W = 32,
    parameter int GAP_SHORT_CYC = GAP_SHORT_MS * CYC_PER_MS,
    parameter int GAP_MEDIUM_CYC = GAP_MEDIUM_MS * CYC_PER_MS,
    parameter int GAP_LONG_CYC = GAP_LONG_MS * CYC_PER_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Decoded scans
    input wire logic scan_valid,
    input wire logic [DATA_W-1:0] scan_data,
    // Link status
    input wire logic in_range,
    input wire logic docked,
    // Operator commands
    input wire logic cmd_valid,
    input wire brs_cmd_e cmd,
    input wire logic [3:0] cmd_digit,
    // Output stream toward base and host
    output logic out_valid,
    input wire logic out_ready,
    output brs_kind_e out_kind,
    output logic [DATA_W-1:0] out_data,
    output logic [19:0] out_qty,
    output logic out_qty_valid,
    output logic [19:0] out_number,
    output logic out_number_valid,
    // Indicators
    output logic scan_beep,
    output logic scan_error,
    output logic scan_forward,
    output logic send_click,
    // Status
    output brs_mode_e mode,
    output logic full,
    output logic [$clog2(DEPTH+1)-1:0] record_count
);

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int IDX_W = $clog2(DEPTH);
    localparam int GAP_W = $clog2(GAP_LONG_CYC + 1);

    // Configuration
    logic click_on, qty_on, numbering_on, lifo, clear_after, auto_send;
    brs_gap_e gap;

    // Storage
    logic [DATA_W-1:0] mem_data [DEPTH];
    logic [15:0] mem_qty [DEPTH];
    logic [CNT_W-1:0] count;
    logic [IDX_W-1:0] newest;

    // Sequencer
    brs_state_e state;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] remaining;
    logic [GAP_W-1:0] gap_cnt, gap_load;
    logic [19:0] number, num_inc;
    logic [15:0] qty_inc, qty_shift;
    logic full_lock, docked_q;

    // Decisions
    logic sending, store_want, cmd_busy, accept_ok, store_ok, merge;
    logic start_send, finish, clear_now, idle_cmd;

    assign record_count = count;
    assign newest = IDX_W'(count - 1'b1);
    assign full = (count == CNT_W'(DEPTH));
    assign sending = (state != BRS_ST_IDLE);
    assign idle_cmd = cmd_valid && !sending;
    assign store_want = scan_valid && (mode == BRS_MODE_INV ||
        (mode == BRS_MODE_AUTO && !in_range));
    assign cmd_busy = cmd_valid && (cmd == clear_all_cmd ||
        cmd == delete_last_cmd || cmd == qty_digit_cmd);
    assign accept_ok = !full && !full_lock && !sending && !start_send &&
        !cmd_busy;
    assign store_ok = store_want && accept_ok;
    assign merge = qty_on && mode == BRS_MODE_INV && count != '0 &&
        mem_data[newest] == scan_data;
    assign start_send = !sending && count != '0 &&
        ((mode == BRS_MODE_AUTO && in_range) ||
         (mode == BRS_MODE_INV && ((cmd_valid &&
           cmd == transmit_records_cmd) ||
          (auto_send && docked && !docked_q))));
    assign finish = state == BRS_ST_SEND && out_ready &&
        remaining == CNT_W'(1);
    assign clear_now = mode == BRS_MODE_AUTO || clear_after;
    assign out_valid = state == BRS_ST_SEND || state == BRS_ST_TOTAL;

    always_comb begin
        case (gap)
            BRS_GAP_SHORT: gap_load = GAP_W'(GAP_SHORT_CYC - 1);
            BRS_GAP_MEDIUM: gap_load = GAP_W'(GAP_MEDIUM_CYC - 1);
            default: gap_load = GAP_W'(GAP_LONG_CYC - 1);
        endcase
    end

    // Decimal helpers for quantity and record number
    brs_bcd_unit #(.DIGITS(QTY_DIGITS)) u_qty (
        .value(mem_qty[newest]),
        .digit(cmd_digit),
        .incremented(qty_inc),
        .shifted(qty_shift)
    );
    brs_bcd_unit #(.DIGITS(NUM_DIGITS)) u_num (
        .value(number),
        .digit(BCD_ZERO),
        .incremented(num_inc),
        .shifted()
    );

    // Configuration commands
    always_ff @(posedge clock) begin
        if (rst) begin
            mode <= BRS_MODE_OFF;
            click_on <= 1'b0;
            qty_on <= 1'b0;
            numbering_on <= 1'b0;
            lifo <= 1'b0;
            clear_after <= 1'b0;
            auto_send <= 1'b0;
            gap <= BRS_GAP_NONE;
        end else if (cmd_valid) begin
            case (cmd)
                batch_off_cmd: mode <= BRS_MODE_OFF;
                auto_batch_select_cmd: mode <= BRS_MODE_AUTO;
                inventory_batch_select_cmd: mode <= BRS_MODE_INV;
                click_on_cmd: click_on <= 1'b1;
                click_off_cmd: click_on <= 1'b0;
                qty_out_on_cmd: qty_on <= 1'b1;
                qty_out_off_cmd: qty_on <= 1'b0;
                numbering_on_cmd: numbering_on <= 1'b1;
                numbering_off_cmd: numbering_on <= 1'b0;
                order_fifo_cmd: lifo <= 1'b0;
                order_lifo_cmd: lifo <= 1'b1;
                clear_after_on_cmd: clear_after <= 1'b1;
                clear_after_off_cmd: clear_after <= 1'b0;
                auto_send_on_cmd: auto_send <= 1'b1;
                auto_send_off_cmd: auto_send <= 1'b0;
                send_gap_none_cmd: gap <= BRS_GAP_NONE;
                send_gap_short_cmd: gap <= BRS_GAP_SHORT;
                send_gap_medium_cmd: gap <= BRS_GAP_MEDIUM;
                send_gap_long_cmd: gap <= BRS_GAP_LONG;
                default: ;
            endcase
        end
    end

    // Record storage and quantities
    always_ff @(posedge clock) begin
        if (store_ok && merge) begin
            mem_qty[newest] <= qty_inc;
        end else if (store_ok) begin
            mem_data[IDX_W'(count)] <= scan_data;
            mem_qty[IDX_W'(count)] <= QTY_DEFAULT;
        end else if (idle_cmd && cmd == qty_digit_cmd && count != '0 &&
                mode != BRS_MODE_OFF && cmd_digit <= BCD_NINE) begin
            mem_qty[newest] <= qty_shift;
        end
    end

    // Record count
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
        end else if (finish && clear_now) begin
            count <= '0;
        end else if (idle_cmd && cmd == clear_all_cmd) begin
            count <= '0;
        end else if (idle_cmd && cmd == delete_last_cmd && count != '0) begin
            count <= count - 1'b1;
        end else if (store_ok && !merge) begin
            count <= count + 1'b1;
        end
    end

    // Lock after a scan meets a full buffer until a transmission completes or the buffer is emptied
    always_ff @(posedge clock) begin
        if (rst) begin
            full_lock <= 1'b0;
        end else if (store_want && full) begin
            full_lock <= 1'b1;
        end else if (finish || count == '0) begin
            full_lock <= 1'b0;
        end
    end

    // Indicator pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            scan_beep <= 1'b0;
            scan_error <= 1'b0;
            scan_forward <= 1'b0;
            send_click <= 1'b0;
            docked_q <= 1'b0;
        end else begin
            scan_beep <= store_ok;
            scan_error <= store_want && !accept_ok;
            scan_forward <= scan_valid && !store_want;
            send_click <= state == BRS_ST_SEND && out_ready && click_on;
            docked_q <= docked;
        end
    end

    // Send sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= BRS_ST_IDLE;
            idx <= '0;
            remaining <= '0;
            gap_cnt <= '0;
            number <= NUM_FIRST;
            out_kind <= BRS_KIND_RECORD;
            out_data <= '0;
            out_qty <= '0;
            out_qty_valid <= 1'b0;
            out_number <= '0;
            out_number_valid <= 1'b0;
        end else begin
            case (state)
                BRS_ST_IDLE: begin
                    if (start_send) begin
                        idx <= lifo ? newest : '0;
                        remaining <= count;
                        number <= NUM_FIRST;
                        state <= BRS_ST_LOAD;
                    end else if (cmd_valid && cmd == total_records_cmd) begin
                        out_kind <= BRS_KIND_TOTAL;
                        out_data <= DATA_W'(count);
                        out_qty_valid <= 1'b0;
                        out_number_valid <= 1'b0;
                        state <= BRS_ST_TOTAL;
                    end
                end
                BRS_ST_LOAD: begin
                    out_kind <= BRS_KIND_RECORD;
                    out_data <= mem_data[idx];
                    out_qty <= {BCD_ZERO, mem_qty[idx]};
                    out_qty_valid <= qty_on && mode == BRS_MODE_INV;
                    out_number <= number;
                    out_number_valid <= numbering_on;
                    state <= BRS_ST_SEND;
                end
                BRS_ST_SEND: begin
                    if (out_ready) begin
                        number <= num_inc;
                        idx <= lifo ? idx - 1'b1 : idx + 1'b1;
                        remaining <= remaining - 1'b1;
                        if (remaining == CNT_W'(1)) begin
                            state <= BRS_ST_IDLE;
                        end else if (gap == BRS_GAP_NONE) begin
                            state <= BRS_ST_LOAD;
                        end else begin
                            gap_cnt <= gap_load;
                            state <= BRS_ST_GAP;
                        end
                    end
                end
                BRS_ST_GAP: begin
                    if (gap_cnt == '0) begin
                        state <= BRS_ST_LOAD;
                    end else begin
                        gap_cnt <= gap_cnt - 1'b1;
                    end
                end
                BRS_ST_TOTAL: begin
                    if (out_ready) begin
                        state <= BRS_ST_IDLE;
                    end
                end
                default: state <= BRS_ST_IDLE;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_start;
        state == BRS_ST_IDLE && start_send;
    endsequence
    sequence s_record_gap;
        state == BRS_ST_SEND && out_ready && remaining != CNT_W'(1) &&
            gap != BRS_GAP_NONE;
    endsequence

    a_reject_full: assert property (store_want && full |=>
        scan_error && !scan_beep) else $error("scan stored while full");
    a_auto_in_range: assert property (mode == BRS_MODE_AUTO && in_range &&
        scan_valid |=> scan_forward && !scan_beep)
        else $error("auto mode stored while in range");
    a_inv_store: assert property (mode == BRS_MODE_INV && store_ok &&
        !merge |=> count == $past(count) + 1'b1)
        else $error("inventory scan not stored");
    a_auto_lock: assert property (mode == BRS_MODE_AUTO && full_lock &&
        store_want |=> scan_error) else $error("auto lock did not hold");
    a_inv_lock: assert property (mode == BRS_MODE_INV && full_lock &&
        store_want |=> scan_error) else $error("inventory lock did not hold");
    a_send_click: assert property (state == BRS_ST_SEND && out_ready &&
        click_on |=> send_click) else $error("missing send click");
    a_delete_last: assert property (idle_cmd && cmd == delete_last_cmd &&
        count != '0 |=> count == $past(count) - 1'b1)
        else $error("delete last failed");
    a_first_number: assert property (s_start |=> ##1
        out_number == NUM_FIRST) else $error("numbering not restarted");
    a_total_out: assert property (idle_cmd && !start_send &&
        cmd == total_records_cmd |=> out_valid && out_kind == BRS_KIND_TOTAL &&
        out_data == DATA_W'($past(count))) else $error("total not presented");
    a_clear_all: assert property (idle_cmd && cmd == clear_all_cmd |=>
        count == '0) else $error("clear all failed");
    a_gap_hold: assert property (s_record_gap |=> !out_valid [*2])
        else $error("gap not inserted");
    a_full_drop: assert property (full && idle_cmd &&
        cmd == delete_last_cmd |=> !full) else $error("full not cleared");

endmodule : brs_batch_record_store

// ---- rtl/brs_pkg.sv ----
// Shared types and constants of the batch record store
package brs_pkg;

    // Batch mode selection
    typedef enum logic [1:0] {
        BRS_MODE_OFF,
        BRS_MODE_AUTO,
        BRS_MODE_INV
    } brs_mode_e;

    // Gap between transmitted records
    typedef enum logic [1:0] {
        BRS_GAP_NONE,
        BRS_GAP_SHORT,
        BRS_GAP_MEDIUM,
        BRS_GAP_LONG
    } brs_gap_e;

    // Kind of item on the output stream
    typedef enum logic {
        BRS_KIND_RECORD,
        BRS_KIND_TOTAL
    } brs_kind_e;

    // Operator commands
    typedef enum logic [4:0] {
        batch_off_cmd,
        auto_batch_select_cmd,
        inventory_batch_select_cmd,
        click_on_cmd,
        click_off_cmd,
        qty_out_on_cmd,
        qty_out_off_cmd,
        numbering_on_cmd,
        numbering_off_cmd,
        order_fifo_cmd,
        order_lifo_cmd,
        clear_after_on_cmd,
        clear_after_off_cmd,
        auto_send_on_cmd,
        auto_send_off_cmd,
        send_gap_none_cmd,
        send_gap_short_cmd,
        send_gap_medium_cmd,
        send_gap_long_cmd,
        delete_last_cmd,
        total_records_cmd,
        clear_all_cmd,
        transmit_records_cmd,
        qty_digit_cmd
    } brs_cmd_e;

    // Send sequencer states
    typedef enum logic [2:0] {
        BRS_ST_IDLE,
        BRS_ST_LOAD,
        BRS_ST_SEND,
        BRS_ST_GAP,
        BRS_ST_TOTAL
    } brs_state_e;

    // Timing
    localparam int CLOCK_HZ = 20_000_000;
    localparam int CYC_PER_MS = CLOCK_HZ / 1000;
    localparam int GAP_SHORT_MS = 250;
    localparam int GAP_MEDIUM_MS = 500;
    localparam int GAP_LONG_MS = 1000;

    // Decimal fields
    localparam int QTY_DIGITS = 4;
    localparam int NUM_DIGITS = 5;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [15:0] QTY_DEFAULT = 16'h0001;
    localparam logic [19:0] NUM_FIRST = 20'h00001;

endpackage : brs_pkg

// ---- rtl/brs_bcd_unit.sv ----
// Decimal digit increment and shift-in for quantity and record number
module brs_bcd_unit import brs_pkg::*; #(
    parameter int DIGITS = 4
) (
    // Current value
    input wire logic [4*DIGITS-1:0] value,
    input wire logic [3:0] digit,
    // Derived values
    output logic [4*DIGITS-1:0] incremented,
    output logic [4*DIGITS-1:0] shifted
);

    logic [DIGITS:0] carry;
    logic [4*DIGITS-1:0] sum;

    assign carry[0] = 1'b1;

    // Ripple decimal carry per digit
    for (genvar i = 0; i < DIGITS; i++) begin : g_digit
        logic [3:0] nib;
        assign nib = value[4*i +: 4];
        assign carry[i+1] = carry[i] && (nib == BCD_NINE);
        assign sum[4*i +: 4] = !carry[i] ? nib :
                               (nib == BCD_NINE) ? BCD_ZERO : nib + 4'h1;
    end

    // Saturate at all nines
    assign incremented = carry[DIGITS] ? value : sum;
    // Oldest digit drops out on the left
    assign shifted = {value[4*DIGITS-5:0], digit};

endmodule : brs_bcd_unit

// ---- verif/brs_base_model.sv ----
// Base station model that takes the record stream from the store
module brs_base_model import brs_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Record stream
    input wire logic out_valid,
    input wire brs_kind_e out_kind,
    input wire logic [31:0] out_data,
    input wire logic [19:0] out_qty,
    input wire logic [19:0] out_number,
    output logic out_ready,
    // Cycles to wait before taking an item
    input wire logic [3:0] stall
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rx_data [$];
    logic [19:0] rx_qty [$];
    logic [19:0] rx_num [$];
    brs_kind_e rx_kind [$];
    int rx_cyc [$];
    int cyc = 0;
    int waited = 0;
    logic took = 1'b0;

    // Capture each item at the edge that hands it over
    always @(posedge clock) begin
        cyc <= cyc + 1;
        took <= out_valid && out_ready;
        if (out_valid && out_ready) begin
            rx_data.push_back(out_data);
            rx_qty.push_back(out_qty);
            rx_num.push_back(out_number);
            rx_kind.push_back(out_kind);
            rx_cyc.push_back(cyc);
        end
    end
    // Ready rises after the stall and falls once the item is taken
    always @(negedge clock) begin
        if (rst || took) begin
            out_ready = 1'b0;
            waited = 0;
        end else if (out_valid === 1'b1 && !out_ready) begin
            if (waited >= stall) out_ready = 1'b1;
            else waited++;
        end
    end
endmodule : brs_base_model

// ---- verif/brs_batch_record_store_bench.sv ----
// Self-checking bench of the batch record store
module brs_batch_record_store_bench import brs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int G_S = 3;
    localparam int G_M = 5;
    localparam int G_L = 8;
    logic clock, rst, scan_valid, in_range, docked, cmd_valid, out_ready;
    logic [31:0] scan_data, out_data;
    brs_cmd_e cmd;
    logic [3:0] cmd_digit, stall;
    logic out_valid, out_qty_valid, out_number_valid, full;
    logic scan_beep, scan_error, scan_forward, send_click;
    brs_kind_e out_kind;
    logic [19:0] out_qty, out_number;
    brs_mode_e mode;
    logic [2:0] record_count;
    int bad_count = 0;
    int n_compared = 0;
    int clicks = 0;
    int click_base = 0;

    brs_batch_record_store #(.DEPTH(4), .DATA_W(32), .GAP_SHORT_CYC(G_S),
        .GAP_MEDIUM_CYC(G_M), .GAP_LONG_CYC(G_L)) dut (.clock(clock),
        .rst(rst), .scan_valid(scan_valid), .scan_data(scan_data),
        .in_range(in_range), .docked(docked), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_digit(cmd_digit), .out_valid(out_valid),
        .out_ready(out_ready), .out_kind(out_kind), .out_data(out_data),
        .out_qty(out_qty), .out_qty_valid(out_qty_valid),
        .out_number(out_number), .out_number_valid(out_number_valid),
        .scan_beep(scan_beep), .scan_error(scan_error),
        .scan_forward(scan_forward), .send_click(send_click), .mode(mode),
        .full(full), .record_count(record_count));
    brs_base_model base (.clock(clock), .rst(rst), .out_valid(out_valid),
        .out_kind(out_kind), .out_data(out_data), .out_qty(out_qty),
        .out_number(out_number), .out_ready(out_ready), .stall(stall));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (send_click === 1'b1) clicks <= clicks + 1;
    end

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic cmd_do(brs_cmd_e c, logic [3:0] d = 4'h0);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd = c;
        cmd_digit = d;
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask : cmd_do

    // Answer bits: beep, error, forward
    task automatic scan_do(logic [31:0] d, logic [2:0] exp);
        @(negedge clock);
        scan_valid = 1'b1;
        scan_data = d;
        @(negedge clock);
        scan_valid = 1'b0;
        check("scan answer", {29'h0, exp},
            {29'h0, scan_beep, scan_error, scan_forward});
    endtask : scan_do

    task automatic flush();
        base.rx_data.delete();
        base.rx_qty.delete();
        base.rx_num.delete();
        base.rx_kind.delete();
        base.rx_cyc.delete();
        click_base = clicks;
    endtask : flush

    task automatic wait_rx(int n);
        int k;
        for (k = 0; k < 3000 && base.rx_data.size() < n; k++) begin
            @(negedge clock);
        end
        if (base.rx_data.size() < n) begin
            bad_count++;
            $display("BAD items expected %0d seen %0d", n, base.rx_data.size());
            wrap_up();
        end
        repeat (4) @(negedge clock);
    endtask : wait_rx

    task automatic t_inventory();
        int i;
        check("reset mode", BRS_MODE_OFF, mode);
        check("reset count", 0, record_count);
        scan_do(32'hF0, 3'b001);
        cmd_do(inventory_batch_select_cmd);
        cmd_do(click_on_cmd);
        cmd_do(numbering_on_cmd);
        in_range = 1'b0;
        for (i = 0; i < 3; i++) begin
            scan_do(32'hA0 + i, 3'b100);
        end
        check("count", 3, record_count);
        stall = 4'h2;
        flush();
        cmd_do(transmit_records_cmd);
        wait_rx(3);
        for (i = 0; i < 3; i++) begin
            check("fifo data", 32'hA0 + i, base.rx_data[i]);
            check("number", i + 1, base.rx_num[i]);
        end
        check("clicks", 3, clicks - click_base);
        check("retained", 3, record_count);
        stall = 4'h0;
        flush();
        cmd_do(order_lifo_cmd);
        cmd_do(clear_after_on_cmd);
        cmd_do(transmit_records_cmd);
        wait_rx(3);
        for (i = 0; i < 3; i++) begin
            check("lifo data", 32'hA2 - i, base.rx_data[i]);
        end
        check("cleared", 0, record_count);
        cmd_do(order_fifo_cmd);
        $display("Test inventory done");
    endtask : t_inventory

    task automatic t_full();
        int i;
        for (i = 0; i < 4; i++) begin
            scan_do(32'hB0 + i, 3'b100);
        end
        check("full", 1, full);
        scan_do(32'hBF, 3'b010);
        cmd_do(delete_last_cmd);
        check("count after delete", 3, record_count);
        check("full after delete", 0, full);
        scan_do(32'hBE, 3'b010);
        flush();
        cmd_do(transmit_records_cmd);
        wait_rx(3);
        check("last kept", 32'hB2, base.rx_data[2]);
        scan_do(32'hC0, 3'b100);
        scan_do(32'hC1, 3'b100);
        flush();
        cmd_do(total_records_cmd);
        wait_rx(1);
        check("total kind", BRS_KIND_TOTAL, base.rx_kind[0]);
        check("total", 2, base.rx_data[0]);
        cmd_do(clear_all_cmd);
        check("clear all", 0, record_count);
        $display("Test full done");
    endtask : t_full

    task automatic t_qty();
        int i;
        cmd_do(qty_out_on_cmd);
        scan_do(32'hD0, 3'b100);
        scan_do(32'hD0, 3'b100);
        check("merged", 1, record_count);
        for (i = 1; i < 6; i++) begin
            cmd_do(qty_digit_cmd, i[3:0]);
        end
        scan_do(32'hD1, 3'b100);
        cmd_do(click_off_cmd);
        flush();
        cmd_do(transmit_records_cmd);
        wait_rx(2);
        check("qty shifted", 20'h02345, base.rx_qty[0]);
        check("qty default", 20'h00001, base.rx_qty[1]);
        check("qty data", 32'hD1, base.rx_data[1]);
        check("qty flag", 1, out_qty_valid);
        check("number flag", 1, out_number_valid);
        check("no clicks", 0, clicks - click_base);
        cmd_do(qty_out_off_cmd);
        $display("Test quantity done");
    endtask : t_qty

    task automatic t_gap();
        brs_cmd_e gc[4];
        int gl[4];
        int g;
        gc = '{send_gap_none_cmd, send_gap_short_cmd, send_gap_medium_cmd,
            send_gap_long_cmd};
        gl = '{0, G_S, G_M, G_L};
        cmd_do(clear_after_off_cmd);
        scan_do(32'hE0, 3'b100);
        scan_do(32'hE1, 3'b100);
        for (g = 0; g < 4; g++) begin
            cmd_do(gc[g]);
            flush();
            cmd_do(transmit_records_cmd);
            wait_rx(2);
            check("gap", 2 + gl[g], base.rx_cyc[1] - base.rx_cyc[0]);
        end
        cmd_do(send_gap_none_cmd);
        cmd_do(auto_send_on_cmd);
        cmd_do(numbering_off_cmd);
        flush();
        docked = 1'b1;
        wait_rx(2);
        check("docked send", 32'hE0, base.rx_data[0]);
        check("number off", 0, out_number_valid);
        docked = 1'b0;
        cmd_do(auto_send_off_cmd);
        flush();
        docked = 1'b1;
        repeat (8) @(negedge clock);
        check("dock no send", 0, base.rx_data.size());
        docked = 1'b0;
        cmd_do(clear_all_cmd);
        $display("Test gap and dock done");
    endtask : t_gap

    task automatic t_auto();
        int i;
        cmd_do(auto_batch_select_cmd);
        check("auto mode", BRS_MODE_AUTO, mode);
        in_range = 1'b1;
        scan_do(32'h10, 3'b001);
        check("live not stored", 0, record_count);
        in_range = 1'b0;
        for (i = 0; i < 4; i++) begin
            scan_do(32'h20 + i, 3'b100);
        end
        scan_do(32'h2F, 3'b010);
        flush();
        in_range = 1'b1;
        wait_rx(4);
        check("drained", 0, record_count);
        check("auto last", 32'h23, base.rx_data[3]);
        in_range = 1'b0;
        scan_do(32'h30, 3'b100);
        cmd_do(batch_off_cmd);
        check("off mode", BRS_MODE_OFF, mode);
        $display("Test automatic done");
    endtask : t_auto

    initial begin
        rst = 1'b1;
        scan_valid = 1'b0;
        scan_data = 32'h0;
        in_range = 1'b1;
        docked = 1'b0;
        cmd_valid = 1'b0;
        cmd = batch_off_cmd;
        cmd_digit = 4'h0;
        stall = 4'h0;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        t_inventory();
        t_full();
        t_qty();
        t_gap();
        t_auto();
        wrap_up();
    end
endmodule : brs_batch_record_store_bench
